// ==== pdor_consts.vh ====
// Constants for the port D override and port register block.
// Assumes a 4-bit register address and 8-bit register data.
`ifndef PDOR_CONSTS_VH
`define PDOR_CONSTS_VH

// Register layout: each port owns three consecutive addresses.
`define PDOR_PORT_STRIDE 3
`define PDOR_PIN_IDX 0
`define PDOR_DIR_IDX 1
`define PDOR_OUT_IDX 2

// Register addresses.
`define PDOR_ADDR_A_PIN 4'h0
`define PDOR_ADDR_A_DIR 4'h1
`define PDOR_ADDR_A_OUT 4'h2
`define PDOR_ADDR_B_PIN 4'h3
`define PDOR_ADDR_B_DIR 4'h4
`define PDOR_ADDR_B_OUT 4'h5
`define PDOR_ADDR_C_PIN 4'h6
`define PDOR_ADDR_C_DIR 4'h7
`define PDOR_ADDR_C_OUT 4'h8
`define PDOR_ADDR_D_PIN 4'h9
`define PDOR_ADDR_D_DIR 4'hA
`define PDOR_ADDR_D_OUT 4'hB
`define PDOR_ADDR_CTRL 4'hC

// Control register fields and reset values.
`define PDOR_CTRL_PUD_BIT 0
`define PDOR_OUT_RESET 8'h00
`define PDOR_DIR_RESET 8'h00
`define PDOR_PUD_RESET 1'h0
`define PDOR_UNMAPPED_READ 8'h00

// Port D pin positions of the alternate functions.
`define PDOR_PD_RX_BIT 0
`define PDOR_PD_TX_BIT 1
`define PDOR_PD_IRQ0_BIT 2
`define PDOR_PD_IRQ1_BIT 3
`define PDOR_PD_CAPTURE_BIT 6

`endif

// ==== pdor_port_regs.v ====
// Output data and direction registers of all ports.
// Assumes one write strobe cycle per write, synchronous to clk.
`include "pdor_consts.vh"

module pdor_port_regs #(
    parameter NUM_PORTS = 4,
    parameter PORT_WIDTH = 8
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire [3:0] reg_addr,
    input wire [PORT_WIDTH-1:0] reg_wdata,
    input wire reg_write,
    output wire [NUM_PORTS*PORT_WIDTH-1:0] out_data,
    output wire [NUM_PORTS*PORT_WIDTH-1:0] direction
);

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1)
        begin : g_port
            localparam [31:0] DIR_SUM =
                p * `PDOR_PORT_STRIDE + `PDOR_DIR_IDX;
            localparam [31:0] OUT_SUM =
                p * `PDOR_PORT_STRIDE + `PDOR_OUT_IDX;
            // Only the low four bits reach the register address.
            localparam [3:0] DIR_ADDR = DIR_SUM[3:0];
            localparam [3:0] OUT_ADDR = OUT_SUM[3:0];
            reg [PORT_WIDTH-1:0] out_reg;
            reg [PORT_WIDTH-1:0] dir_reg;

            // Both registers clear at reset so every pin starts as a
            // tri-stated input without pull-up.
            always @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    out_reg <= `PDOR_OUT_RESET;
                    dir_reg <= `PDOR_DIR_RESET;
                end
                else if (clk_en && reg_write)
                begin
                    if (reg_addr == OUT_ADDR)
                        out_reg <= reg_wdata;
                    if (reg_addr == DIR_ADDR)
                        dir_reg <= reg_wdata;
                end
            end

            assign out_data[p*PORT_WIDTH +: PORT_WIDTH] = out_reg;
            assign direction[p*PORT_WIDTH +: PORT_WIDTH] = dir_reg;
        end
    endgenerate

endmodule // pdor_port_regs

// ==== pdor_pin_cell.v ====
// One pin: override multiplexers for direction, value, pull-up and
// input buffer, plus the registered pin drive and sampled level.
// Assumes the pin input is synchronous to clk.

module pdor_pin_cell (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire out_bit,
    input wire dir_bit,
    input wire pullup_disable,
    input wire sleep_input_off,
    input wire pullup_override_en,
    input wire pullup_override_val,
    input wire dir_override_en,
    input wire dir_override_val,
    input wire value_override_en,
    input wire value_override_val,
    input wire input_buf_override_en,
    input wire input_buf_override_val,
    input wire pin_in,
    output reg pin_out,
    output reg pin_oe,
    output reg pin_pullup_en,
    output reg pin_input_buf_en,
    output reg pin_level
);

    reg next_oe;
    reg next_out;
    reg next_pullup;
    reg next_buf;

    // An override enable hands the pin attribute to the peripheral;
    // otherwise the port registers decide, and sleep_input_off decides the input buffer.
    always @*
    begin
        next_oe = dir_override_en ? dir_override_val : dir_bit;
        next_out = value_override_en ? value_override_val
                                     : out_bit;
        next_pullup = pullup_override_en ? pullup_override_val
                    : (~dir_bit & out_bit & ~pullup_disable);
        next_buf = input_buf_override_en ? input_buf_override_val
                                         : ~sleep_input_off;
    end

    // Registered drive; the level is gated by the buffer in use.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out <= 1'h0;
            pin_oe <= 1'h0;
            pin_pullup_en <= 1'h0;
            pin_input_buf_en <= 1'h1;
            pin_level <= 1'h0;
        end
        else if (clk_en)
        begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            pin_pullup_en <= next_pullup;
            pin_input_buf_en <= next_buf;
            pin_level <= pin_in & pin_input_buf_en;
        end
    end

endmodule // pdor_pin_cell

// ==== pdor_top.v ====
// Port registers for ports A to D and the port D alternate-function
// override logic, with a simple strobe register port.
// Assumes all peripheral signals and pin inputs are synchronous to clk.
//
// Operation
// - Port D bit 3 level goes to external interrupt 1 logic.
// - Port D bit 2 level goes to external interrupt 0 logic.
// - Enabled external interrupt forces only its pin input buffer on.
// - Transmitter enable: D1 output, drives transmit data, pull-up off.
// - Receiver enable forces D0 input and feeds its level to receiver.
// - Forced D0 pull-up follows its output data bit and pull-up disable.
// - Enabled compare outputs replace output values of D7, D5, D4 only.
// - Port D bit 6 level feeds timer 1 capture, no overrides.
// - Each port has an 8-bit output data register, reset to zero.
// - Each port has an 8-bit direction register, reset to zero.
// - Each port has a read-only input register with the pin levels.
`include "pdor_consts.vh"

module pdor_top #(
    parameter NUM_PORTS = 4,
    parameter PORT_WIDTH = 8
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    input wire [31:0] pin_in,
    output wire [31:0] pin_out,
    output wire [31:0] pin_oe,
    output wire [31:0] pin_pullup_en,
    output wire [31:0] pin_input_buf_en,
    input wire sleep_input_off,
    input wire transmitter_enable,
    input wire tx_data,
    input wire receiver_enable,
    output wire rx_data_in,
    input wire timer2_compare_en,
    input wire timer2_compare_out,
    input wire timer1_compare_a_en,
    input wire timer1_compare_a_out,
    input wire timer1_compare_b_en,
    input wire timer1_compare_b_out,
    output wire timer1_capture_in,
    input wire ext_irq_one_enable,
    input wire ext_irq_zero_enable,
    output wire ext_irq_one_input,
    output wire ext_irq_zero_input
);

    localparam NUM_PINS = NUM_PORTS * PORT_WIDTH;

    wire [NUM_PINS-1:0] out_data;
    wire [NUM_PINS-1:0] direction;
    wire [NUM_PINS-1:0] pin_level;
    reg global_pullup_disable;

    wire [7:0] pd_out;
    wire [7:0] pd_pu_oe;
    wire [7:0] pd_pu_ov;
    wire [7:0] pd_dd_oe;
    wire [7:0] pd_dd_ov;
    wire [7:0] pd_pv_oe;
    wire [7:0] pd_pv_ov;
    wire [7:0] pd_die_oe;
    wire [7:0] pd_die_ov;

    wire [NUM_PINS-1:0] pullup_override_en;
    wire [NUM_PINS-1:0] pullup_override_val;
    wire [NUM_PINS-1:0] dir_override_en;
    wire [NUM_PINS-1:0] dir_override_val;
    wire [NUM_PINS-1:0] value_override_en;
    wire [NUM_PINS-1:0] value_override_val;
    wire [NUM_PINS-1:0] input_buf_override_en;
    wire [NUM_PINS-1:0] input_buf_override_val;

    // Output data and direction registers of every port.
    pdor_port_regs #(
        .NUM_PORTS(NUM_PORTS),
        .PORT_WIDTH(PORT_WIDTH)
    ) u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .out_data(out_data),
        .direction(direction)
    );

    assign pd_out = out_data[NUM_PINS-1 -: 8];

    // Pull-up overrides: the transmitter forces its pull-up off, the
    // receiver leaves it to the output data bit under the global disable.
    assign pd_pu_oe = {6'h00, transmitter_enable, receiver_enable};
    assign pd_pu_ov = {6'h00, 1'h0,
                       pd_out[`PDOR_PD_RX_BIT] &
                       ~global_pullup_disable};

    // Direction overrides: transmit pin forced out, receive pin in.
    assign pd_dd_oe = {6'h00, transmitter_enable,
                       receiver_enable};
    assign pd_dd_ov = {6'h00, 1'h1, 1'h0};

    // Value overrides. Compare outputs touch only the value, so the pin
    // shows them only after software has made it an output.
    assign pd_pv_oe = {timer2_compare_en, 1'h0, timer1_compare_a_en,
                       timer1_compare_b_en, 2'h0,
                       transmitter_enable, 1'h0};
    assign pd_pv_ov = {timer2_compare_out, 1'h0, timer1_compare_a_out,
                       timer1_compare_b_out, 2'h0,
                       tx_data, 1'h0};

    // Interrupt pins keep their input buffer alive even when the buffers
    // are switched off for power saving.
    assign pd_die_oe = {4'h0, ext_irq_one_enable, ext_irq_zero_enable,
                        2'h0};
    assign pd_die_ov = {4'h0, 1'h1, 1'h1, 2'h0};

    // Ports A to C carry no overrides in this block.
    assign pullup_override_en = {pd_pu_oe, {(NUM_PINS-8){1'b0}}};
    assign pullup_override_val = {pd_pu_ov, {(NUM_PINS-8){1'b0}}};
    assign dir_override_en = {pd_dd_oe, {(NUM_PINS-8){1'b0}}};
    assign dir_override_val = {pd_dd_ov, {(NUM_PINS-8){1'b0}}};
    assign value_override_en = {pd_pv_oe, {(NUM_PINS-8){1'b0}}};
    assign value_override_val = {pd_pv_ov, {(NUM_PINS-8){1'b0}}};
    assign input_buf_override_en = {pd_die_oe, {(NUM_PINS-8){1'b0}}};
    assign input_buf_override_val = {pd_die_ov, {(NUM_PINS-8){1'b0}}};

    // One cell per pin holds the registered drive and the sampled level.
    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i = i + 1)
        begin : g_pin
            pdor_pin_cell u_cell (
                .clk(clk),
                .reset_n(reset_n),
                .clk_en(clk_en),
                .out_bit(out_data[i]),
                .dir_bit(direction[i]),
                .pullup_disable(global_pullup_disable),
                .sleep_input_off(sleep_input_off),
                .pullup_override_en(pullup_override_en[i]),
                .pullup_override_val(pullup_override_val[i]),
                .dir_override_en(dir_override_en[i]),
                .dir_override_val(dir_override_val[i]),
                .value_override_en(value_override_en[i]),
                .value_override_val(value_override_val[i]),
                .input_buf_override_en(input_buf_override_en[i]),
                .input_buf_override_val(input_buf_override_val[i]),
                .pin_in(pin_in[i]),
                .pin_out(pin_out[i]),
                .pin_oe(pin_oe[i]),
                .pin_pullup_en(pin_pullup_en[i]),
                .pin_input_buf_en(pin_input_buf_en[i]),
                .pin_level(pin_level[i])
            );
        end
    endgenerate

    // Alternate-function inputs tap the sampled levels, so the peripherals
    // see the same value that software reads back.
    assign ext_irq_one_input =
        pin_level[NUM_PINS-8+`PDOR_PD_IRQ1_BIT];
    assign ext_irq_zero_input =
        pin_level[NUM_PINS-8+`PDOR_PD_IRQ0_BIT];
    assign rx_data_in = pin_level[NUM_PINS-8+`PDOR_PD_RX_BIT];
    assign timer1_capture_in =
        pin_level[NUM_PINS-8+`PDOR_PD_CAPTURE_BIT];

    // Global pull-up disable lives in the control register.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            global_pullup_disable <= `PDOR_PUD_RESET;
        else if (clk_en && reg_write && reg_addr == `PDOR_ADDR_CTRL)
            global_pullup_disable <= reg_wdata[`PDOR_CTRL_PUD_BIT];
    end

    // Read data stand only in the cycle after the read strobe; the pin
    // level registers have no write path and ignore writes.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (clk_en)
        begin
            if (!reg_read)
                reg_rdata <= 8'h00;
            else
            begin
                case (reg_addr)
                    `PDOR_ADDR_A_PIN: reg_rdata <= pin_level[7:0];
                    `PDOR_ADDR_A_DIR: reg_rdata <= direction[7:0];
                    `PDOR_ADDR_A_OUT: reg_rdata <= out_data[7:0];
                    `PDOR_ADDR_B_PIN: reg_rdata <= pin_level[15:8];
                    `PDOR_ADDR_B_DIR: reg_rdata <= direction[15:8];
                    `PDOR_ADDR_B_OUT: reg_rdata <= out_data[15:8];
                    `PDOR_ADDR_C_PIN: reg_rdata <= pin_level[23:16];
                    `PDOR_ADDR_C_DIR: reg_rdata <= direction[23:16];
                    `PDOR_ADDR_C_OUT: reg_rdata <= out_data[23:16];
                    `PDOR_ADDR_D_PIN: reg_rdata <= pin_level[31:24];
                    `PDOR_ADDR_D_DIR: reg_rdata <= direction[31:24];
                    `PDOR_ADDR_D_OUT: reg_rdata <= out_data[31:24];
                    `PDOR_ADDR_CTRL:
                        reg_rdata <= {7'h00, global_pullup_disable};
                    default: reg_rdata <= `PDOR_UNMAPPED_READ;
                endcase
            end
        end
    end

endmodule // pdor_top

// ==== pdor_pin_model.sv ====
// Board model around the port pins: outside drivers and pull-ups.
// Assumes the pin outputs of the block are registered.
module pdor_pin_model (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pin_pullup_en,
    input wire logic [31:0] ext_level,
    input wire logic [31:0] ext_drive,
    output logic [31:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // An outside driver beats a pull-up; a floating pin without pull-up
    // reads the inverse of its last drive, so a lost drive shows at once.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level)
        | (~pin_oe & ~ext_drive & (pin_pullup_en | ~pin_out));
endmodule // pdor_pin_model

// ==== pdor_top_asserts.sv ====
// Checker for the port block: pin overrides and peripheral levels.
// Assumes it is bound to pdor_top and sees only its ports.
module pdor_top_asserts (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire [31:0] pin_in,
    input wire [31:0] pin_out,
    input wire [31:0] pin_oe,
    input wire [31:0] pin_pullup_en,
    input wire [31:0] pin_input_buf_en,
    input wire sleep_input_off,
    input wire transmitter_enable,
    input wire tx_data,
    input wire receiver_enable,
    input wire rx_data_in,
    input wire timer2_compare_en,
    input wire timer2_compare_out,
    input wire timer1_capture_in,
    input wire ext_irq_one_enable,
    input wire ext_irq_zero_enable,
    input wire ext_irq_one_input,
    input wire ext_irq_zero_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // All checks share the one clock and rest while reset is low.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_tx_drive;
        transmitter_enable && clk_en |=> pin_oe[25] && !pin_pullup_en[25]
            && pin_out[25] == $past(tx_data);
    endproperty
    a_tx_drive: assert property (p_tx_drive)
        else $error("transmit pin not driven");
    property p_rx_input;
        receiver_enable && clk_en |=> !pin_oe[24];
    endproperty
    a_rx_input: assert property (p_rx_input)
        else $error("receive pin driven");
    property p_rx_level;
        clk_en |=> rx_data_in == $past(pin_in[24] & pin_input_buf_en[24]);
    endproperty
    a_rx_level: assert property (p_rx_level)
        else $error("receive level wrong");
    property p_irq_level;
        clk_en ##1 1'b1 |-> ext_irq_one_input == $past(pin_in[27]
            & pin_input_buf_en[27]) && ext_irq_zero_input == $past(pin_in[26]
            & pin_input_buf_en[26]);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level wrong");
    property p_capture;
        clk_en |=> timer1_capture_in
            == $past(pin_in[30] & pin_input_buf_en[30]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture level wrong");
    property p_irq_buf;
        clk_en |=> (!$past(ext_irq_one_enable) || pin_input_buf_en[27])
            && (!$past(ext_irq_zero_enable) || pin_input_buf_en[26]);
    endproperty
    a_irq_buf: assert property (p_irq_buf)
        else $error("interrupt input buffer off");
    property p_sleep_off;
        sleep_input_off && !ext_irq_one_enable && clk_en |=>
            !pin_input_buf_en[27] && pin_input_buf_en[7:0] == 8'h00;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("input buffer on without override");
    property p_cmp_value;
        timer2_compare_en && clk_en |=>
            pin_out[31] == $past(timer2_compare_out);
    endproperty
    a_cmp_value: assert property (p_cmp_value)
        else $error("compare value not on pin");
endmodule // pdor_top_asserts

// Attach the checker to every instance of the port block.
bind pdor_top pdor_top_asserts i_pdor_top_asserts (
    .clk, .reset_n, .clk_en, .pin_in, .pin_out, .pin_oe, .pin_pullup_en,
    .pin_input_buf_en, .sleep_input_off, .transmitter_enable, .tx_data,
    .receiver_enable, .rx_data_in, .timer2_compare_en, .timer2_compare_out,
    .timer1_capture_in, .ext_irq_one_enable, .ext_irq_zero_enable,
    .ext_irq_one_input, .ext_irq_zero_input
);

// ==== tb_top.sv ====
// Self-checking bench for the port block with a board model on its pins.
// Assumes the design files and the checker are compiled before this one.
`include "pdor_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, clk_en, reg_write, reg_read;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [31:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_input_buf_en;
    logic [31:0] ext_level, ext_drive;
    logic sleep_input_off, transmitter_enable, tx_data, receiver_enable;
    logic rx_data_in, timer1_capture_in, ext_irq_one_input, ext_irq_zero_input;
    logic timer2_compare_en, timer2_compare_out, timer1_compare_a_en;
    logic timer1_compare_a_out, timer1_compare_b_en, timer1_compare_b_out;
    logic ext_irq_one_enable, ext_irq_zero_enable;
    int fails;
    int samples_checked;
    pdor_top i_pdor_top (
        .clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .pin_in, .pin_out, .pin_oe, .pin_pullup_en,
        .pin_input_buf_en, .sleep_input_off, .transmitter_enable, .tx_data,
        .receiver_enable, .rx_data_in, .timer2_compare_en, .timer2_compare_out,
        .timer1_compare_a_en, .timer1_compare_a_out, .timer1_compare_b_en,
        .timer1_compare_b_out, .timer1_capture_in, .ext_irq_one_enable,
        .ext_irq_zero_enable, .ext_irq_one_input, .ext_irq_zero_input
    );
    pdor_pin_model i_pdor_pin_model (
        .pin_out, .pin_oe, .pin_pullup_en, .ext_level, .ext_drive, .pin_in
    );
    // The 50 MHz clock.
    always #10 clk = ~clk;
    // Compares, counts and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // Bus cycles start at a rising edge and end one edge after the strobe
    // drops, so a strobe is never lowered and raised in one time step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", e, reg_rdata);
        @(posedge clk);
    endtask
    // Pin drive takes one edge, the sampled level one more.
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_regs;
        logic [7:0] d;
        logic [7:0] o;
        for (int p = 0; p < 4; p++)
        begin
            d = 8'h3C ^ 8'(p);
            o = 8'hA5 ^ 8'(p);
            rd(4'(p * 3 + 1), 8'h00);
            rd(4'(p * 3 + 2), 8'h00);
            wr(4'(p * 3 + 1), d);
            wr(4'(p * 3 + 2), o);
            wr(4'(p * 3), 8'hFF);
            rd(4'(p * 3 + 1), d);
            rd(4'(p * 3 + 2), o);
            rd(4'(p * 3), (d & o) | (~d & 8'h0F));
            chk("pin_oe", d, pin_oe[p * 8 +: 8]);
            chk("pin_out", o, pin_out[p * 8 +: 8]);
        end
        wr(4'hE, 8'h5A);
        rd(4'hE, 8'h00);
    endtask
    task automatic t_serial;
        wr(`PDOR_ADDR_D_DIR, 8'h01);
        wr(`PDOR_ADDR_D_OUT, 8'h03);
        {transmitter_enable, receiver_enable} <= 2'h3;
        // Receive pin starts low so the later rise proves the level path.
        ext_level[24] <= 1'b0;
        settle;
        chk("tx oe pull out", 3'h4,
            {pin_oe[25], pin_pullup_en[25], pin_out[25]});
        chk("rx oe pull lvl", 3'h2,
            {pin_oe[24], pin_pullup_en[24], rx_data_in});
        @(posedge clk);
        tx_data <= 1'b1;
        ext_level[24] <= 1'b1;
        wr(`PDOR_ADDR_CTRL, 8'h01);
        settle;
        chk("tx out", 1'h1, pin_out[25]);
        chk("rx pull lvl", 2'h1,
            {pin_pullup_en[24], rx_data_in});
        @(posedge clk);
        {transmitter_enable, receiver_enable} <= 2'h0;
        wr(`PDOR_ADDR_CTRL, 8'h00);
        settle;
        // Direction 01 leaves D1 an input with pull-up and D0 an output.
        chk("released", 3'h3, {pin_oe[25:24], pin_pullup_en[25]});
        @(posedge clk);
    endtask
    task automatic t_cmp;
        wr(`PDOR_ADDR_D_DIR, 8'hFF);
        wr(`PDOR_ADDR_D_OUT, 8'h00);
        {timer2_compare_en, timer1_compare_a_en} <= 2'h3;
        timer1_compare_b_en <= 1'b1;
        {timer2_compare_out, timer1_compare_a_out} <= 2'h3;
        timer1_compare_b_out <= 1'b1;
        settle;
        chk("cmp out", 8'hB0, pin_out[31:24]);
        chk("cmp oe", 8'hFF, pin_oe[31:24]);
        @(posedge clk);
        {timer2_compare_out, timer1_compare_a_out} <= 2'h0;
        timer1_compare_b_out <= 1'b0;
        wr(`PDOR_ADDR_D_OUT, 8'hFF);
        settle;
        chk("cmp out", 8'h4F, pin_out[31:24]);
        @(posedge clk);
        {timer2_compare_en, timer1_compare_a_en} <= 2'h0;
        timer1_compare_b_en <= 1'b0;
    endtask
    task automatic t_irq;
        wr(`PDOR_ADDR_D_DIR, 8'h00);
        {sleep_input_off, ext_irq_one_enable} <= 2'h3;
        ext_level[31:24] <= 8'h4C;
        settle;
        chk("irq buf", 8'h08, pin_input_buf_en[31:24]);
        chk("irq levels", 2'h2,
            {ext_irq_one_input, ext_irq_zero_input});
        chk("irq oe pull", 2'h1, {pin_oe[27], pin_pullup_en[27]});
        @(posedge clk);
        {ext_irq_one_enable, ext_irq_zero_enable} <= 2'h1;
        settle;
        chk("irq buf", 8'h04, pin_input_buf_en[31:24]);
        chk("irq levels", 2'h1,
            {ext_irq_one_input, ext_irq_zero_input});
        @(posedge clk);
        {sleep_input_off, ext_irq_zero_enable} <= 2'h0;
        settle;
        chk("capture", 2'h1, {pin_oe[30], timer1_capture_in});
        @(posedge clk);
    endtask
    // A low clock enable must hold every register, so this write is lost.
    task automatic t_freeze;
        clk_en <= 1'b0;
        wr(`PDOR_ADDR_D_OUT, 8'h12);
        clk_en <= 1'b1;
        rd(`PDOR_ADDR_D_OUT, 8'hFF);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence: quiet inputs, six cycles of reset, then the scenarios.
    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        {reg_addr, reg_wdata, reg_write, reg_read, sleep_input_off} = '0;
        {transmitter_enable, tx_data, receiver_enable, timer2_compare_en} = '0;
        {timer2_compare_out, timer1_compare_a_en, timer1_compare_a_out} = '0;
        {timer1_compare_b_en, timer1_compare_b_out} = '0;
        {ext_irq_one_enable, ext_irq_zero_enable} = '0;
        ext_drive = 32'hFFFFFFFF;
        ext_level = 32'h0F0F0F0F;
        fails = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_serial;
        t_cmp;
        t_irq;
        t_freeze;
        test_done;
    end
    // The scenarios need well under a thousand cycles; five thousand
    // leaves room without letting a hang run long.
    initial
    begin
        #100000;
        fails++;
        test_done;
    end
endmodule // tb_top
